//--- logic/capture_defines.svh
`ifndef CAPTURE_DEFINES_SVH
`define CAPTURE_DEFINES_SVH

// One state time equals one clock cycle of clock_in (20 ns at 50 MHz)
`define CLK_PERIOD_NS 20
// Capture sampling resolution in state times
`define SAMPLE_STATES 9
// Time-tag timer prescale in state times
`define TIMER_STATES 8
// Delay before the first entry moves into the holding register, in state times
`define HOLD_MOVE_STATES 8
// Default number of event input lines and timer width
`define LINES_DEFAULT 4
`define TIMER_W_DEFAULT 16
`define FIFO_DEPTH_DEFAULT 8
// Reset values
`define TIMER_RESET 16'h0000

`endif

//--- logic/capture_pkg.sv
package capture_pkg;

	// Slot sequencer of the buffer front end
	typedef enum logic [2:0] {
		SLOT_EMPTY = 3'b001,
		SLOT_FIRST = 3'b010,
		SLOT_HOLD = 3'b100
	} slot_state_t;

endpackage : capture_pkg

//--- logic/capture_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// Flip-flop FIFO with valid/ready on both sides
module capture_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial begin
		if (DEPTH < 2 || WIDTH < 1) begin
			$error("capture_fifo: DEPTH must be at least 2 and WIDTH at least 1");
		end
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	// Handshakes and pointer update
	always_comb begin
		push = in_valid_in && (count != (AW+1)'(DEPTH));
		pop = (count != '0) && out_ready_in;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push) begin
			next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count <= '0;
		end else begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count <= next_count;
		end
	end

	// Storage has no reset; only written entries are ever shown
	always_ff @(posedge clock_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	assign in_ready_out = (count != (AW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign out_data_out = mem[rd_ptr];

endmodule : capture_fifo

`default_nettype wire

//--- logic/event_time_capture_fifo.sv
// What this block does
// - Sample event lines every nine states
// - Timer steps by one every eight states; sampled tags skip values
// - Tag may be one count late
// - Next sample lands after SLOT_FIRST ends (8 < 9)
// - So every entry is tagged with the plain timer
// - First entry moves to holding after eight
// - Later event acts as new first
`timescale 1ns/1ps
`default_nettype none
`include "capture_defines.svh"

module event_time_capture_fifo #(
	parameter int LINES = `LINES_DEFAULT,
	parameter int TIMER_W = `TIMER_W_DEFAULT,
	parameter int DEPTH = `FIFO_DEPTH_DEFAULT
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Event input lines
	input wire logic [LINES-1:0] event_lines_in,
	// Holding register read port
	input wire logic hold_read_in,
	output logic hold_valid_out,
	output logic [LINES-1:0] hold_lines_out,
	output logic [TIMER_W-1:0] hold_tag_out,
	// Free-running time-tag timer
	output logic [TIMER_W-1:0] timer_out,
	// Sticky loss flag: an event found the FIFO full and was dropped
	output logic overflow_out
);
	localparam int SAMPLE_N = `SAMPLE_STATES;
	localparam int TIMER_N = `TIMER_STATES;
	localparam int HOLD_N = `HOLD_MOVE_STATES;
	localparam int ENTRY_W = LINES + TIMER_W;

	initial begin
		if (LINES < 1 || TIMER_W < 4 || DEPTH < 2) begin
			$error("event_time_capture_fifo: unsupported LINES, TIMER_W or DEPTH");
		end
	end

	// Wrap test for the small state-time dividers
	function automatic logic at_last(input logic [3:0] cnt, input int n);
		at_last = (cnt == 4'(n - 1));
	endfunction : at_last

	// ---- Dividers and timer ----
	logic [3:0] sample_div, next_sample_div;
	logic [3:0] timer_div, next_timer_div;
	logic [TIMER_W-1:0] timer, next_timer;
	logic sample_tick;
	logic timer_tick;

	// Sample every nine states, time base every eight
	always_comb begin
		sample_tick = at_last(sample_div, SAMPLE_N);
		timer_tick = at_last(timer_div, TIMER_N);
		next_sample_div = sample_tick ? 4'h0 : sample_div + 4'h1;
		next_timer_div = timer_tick ? 4'h0 : timer_div + 4'h1;
		next_timer = timer_tick ? timer + 1'b1 : timer;
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			sample_div <= 4'h0;
			timer_div <= 4'h0;
			timer <= `TIMER_RESET;
		end else begin
			sample_div <= next_sample_div;
			timer_div <= next_timer_div;
			timer <= next_timer;
		end
	end

	// ---- Edge capture ----
	// Edges are latched between sample points; a second edge on the
	// same line inside one nine-state window merges into the first
	logic [LINES-1:0] prev_lines, next_prev_lines;
	logic [LINES-1:0] pend, next_pend;
	logic [LINES-1:0] seen;
	// The timer value latched at the last sample point; since samples
	// come every nine states while the timer moves every eight, one
	// value in nine is never latched
	logic [TIMER_W-1:0] sampled_time, next_sampled_time;
	logic [TIMER_W-1:0] skipped_guess;

	always_comb begin
		seen = pend | (event_lines_in ^ prev_lines);
		next_prev_lines = event_lines_in;
		next_pend = sample_tick ? '0 : seen;
		// Tag is the timer seen at the sample point, so it may lag the
		// true event by up to one skipped count
		// The timer value standing before the sample edge is used, so the
		// lag behind the event never exceeds one timer step
		next_sampled_time = sample_tick ? timer : sampled_time;
		skipped_guess = sampled_time + TIMER_W'(2);
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			prev_lines <= '0;
			pend <= '0;
			sampled_time <= `TIMER_RESET;
		end else begin
			prev_lines <= next_prev_lines;
			pend <= next_pend;
			sampled_time <= next_sampled_time;
		end
	end

	// ---- Front end: first-entry tagging and holding transfer ----
	capture_pkg::slot_state_t state, next_state;
	logic [3:0] move_cnt, next_move_cnt;
	logic [TIMER_W-1:0] first_tag, next_first_tag;
	logic [LINES-1:0] entry_lines;
	logic [TIMER_W-1:0] entry_tag;
	logic push;
	logic fifo_ready;
	logic fifo_valid;
	logic fifo_pop;
	logic [ENTRY_W-1:0] fifo_data;
	logic hold_load;
	logic fifo_was_empty;

	// An event at a sample point becomes one entry; the next sample comes
	// only after SLOT_FIRST ends, so no entry is tagged relative to another
	always_comb begin
		next_state = state;
		next_move_cnt = move_cnt;
		next_first_tag = first_tag;
		entry_lines = seen;
		entry_tag = timer;
		push = sample_tick && (seen != '0) && fifo_ready;
		case (state)
			capture_pkg::SLOT_EMPTY: begin
				if (push) begin
					next_state = capture_pkg::SLOT_FIRST;
					next_move_cnt = 4'h0;
					next_first_tag = timer;
				end
			end
			capture_pkg::SLOT_FIRST: begin
				if (sample_tick && (seen != '0)) begin
					if (move_cnt == 4'h0) begin
						entry_tag = first_tag;
					end else if (timer == skipped_guess) begin
						entry_tag = first_tag + TIMER_W'(2);
					end else begin
						entry_tag = first_tag + TIMER_W'(1);
					end
					next_state = capture_pkg::SLOT_HOLD;
				end else if (at_last(move_cnt, HOLD_N)) begin
					next_state = capture_pkg::SLOT_HOLD;
				end else begin
					next_move_cnt = move_cnt + 4'h1;
				end
			end
			capture_pkg::SLOT_HOLD: begin
				// Once the FIFO drains, the next event is a new first
				if (fifo_was_empty && !push) begin
					next_state = capture_pkg::SLOT_EMPTY;
				end else if (fifo_was_empty && push) begin
					next_state = capture_pkg::SLOT_FIRST;
					next_move_cnt = 4'h0;
					next_first_tag = timer;
				end
			end
			default: begin
				next_state = capture_pkg::SLOT_EMPTY;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			state <= capture_pkg::SLOT_EMPTY;
			move_cnt <= 4'h0;
			first_tag <= `TIMER_RESET;
		end else begin
			state <= next_state;
			move_cnt <= next_move_cnt;
			first_tag <= next_first_tag;
		end
	end

	// ---- FIFO ----
	capture_fifo #(
		.WIDTH(ENTRY_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(push),
		.in_ready_out(fifo_ready),
		.in_data_in({entry_lines, entry_tag}),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_data)
	);

	// ---- Holding register ----
	logic hold_valid, next_hold_valid;
	logic [LINES-1:0] hold_lines, next_hold_lines;
	logic [TIMER_W-1:0] hold_tag, next_hold_tag;
	logic overflow, next_overflow;

	// The holding register only pulls from the FIFO after the first
	// entry has sat eight states, or later entries when it is free
	always_comb begin
		fifo_was_empty = !fifo_valid;
		hold_load = fifo_valid && (!hold_valid || hold_read_in) &&
			!(state == capture_pkg::SLOT_FIRST && !at_last(move_cnt, HOLD_N));
		fifo_pop = hold_load;
		next_hold_valid = hold_valid;
		next_hold_lines = hold_lines;
		next_hold_tag = hold_tag;
		if (hold_read_in) begin
			next_hold_valid = 1'b0;
		end
		if (hold_load) begin
			next_hold_valid = 1'b1;
			next_hold_lines = fifo_data[ENTRY_W-1:TIMER_W];
			next_hold_tag = fifo_data[TIMER_W-1:0];
		end
		// Sticky loss flag; a read of the holding register clears it,
		// but a fresh loss in that cycle wins
		next_overflow = (overflow && !hold_read_in) ||
			(sample_tick && (seen != '0) && !fifo_ready);
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			hold_valid <= 1'b0;
			hold_lines <= '0;
			hold_tag <= `TIMER_RESET;
			overflow <= 1'b0;
		end else begin
			hold_valid <= next_hold_valid;
			hold_lines <= next_hold_lines;
			hold_tag <= next_hold_tag;
			overflow <= next_overflow;
		end
	end

	// Outputs come straight from flip-flops
	assign hold_valid_out = hold_valid;
	assign hold_lines_out = hold_lines;
	assign hold_tag_out = hold_tag;
	assign timer_out = timer;
	assign overflow_out = overflow;

endmodule : event_time_capture_fifo

`default_nettype wire

//--- verification/capture_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level watch on the capture block
module capture_checker #(
	parameter int LINES = 4,
	parameter int TIMER_W = 16
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Event side
	input wire logic [LINES-1:0] event_lines_in,
	input wire logic hold_read_in,
	// Holding register and timer
	input wire logic hold_valid_out,
	input wire logic [LINES-1:0] hold_lines_out,
	input wire logic [TIMER_W-1:0] hold_tag_out,
	input wire logic [TIMER_W-1:0] timer_out,
	input wire logic overflow_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	// Timer rests seven states, then steps by exactly one
	step_one_a: assert property (
		$changed(timer_out) |=> $stable(timer_out)[*7] ##1
		timer_out == TIMER_W'($past(timer_out) + 1'b1)) else $error("timer step wrong");
	// Entry stands until read
	hold_stand_a: assert property (
		hold_valid_out && !hold_read_in |=> hold_valid_out && $stable(hold_tag_out)
		&& $stable(hold_lines_out)) else $error("holding entry moved");
	mask_set_a: assert property (
		hold_valid_out |-> hold_lines_out != '0) else $error("entry without lines");
	reset_clear_a: assert property (
		$rose(rst_n_in) |-> !hold_valid_out && !overflow_out && timer_out == '0)
		else $error("outputs not clear after reset");
	overflow_hold_a: assert property (
		overflow_out && !hold_read_in |=> overflow_out) else $error("overflow dropped");
	overflow_full_a: assert property (
		$rose(overflow_out) |-> hold_valid_out) else $error("overflow while empty");
	// Within 20 cycles of any event change the holding register holds a valid entry
	event_lands_a: assert property (
		$changed(event_lines_in) |-> ##[1:20] hold_valid_out) else $error("event never held");
	// An idle block cannot hold a fresh event before sampling and the move delay
	hold_late_a: assert property (
		($stable(event_lines_in) && !hold_valid_out)[*8] ##1 $changed(event_lines_in)
		|=> !hold_valid_out[*6]) else $error("entry held too early");
	cover property (hold_valid_out && hold_read_in);
	cover property ($rose(overflow_out));
	cover property ($changed(event_lines_in) && !hold_valid_out);
endmodule : capture_checker
bind event_time_capture_fifo capture_checker #(.LINES(LINES), .TIMER_W(TIMER_W)) chk (
	.clock_in(clock_in), .rst_n_in(rst_n_in), .event_lines_in(event_lines_in),
	.hold_read_in(hold_read_in), .hold_valid_out(hold_valid_out),
	.hold_lines_out(hold_lines_out), .hold_tag_out(hold_tag_out),
	.timer_out(timer_out), .overflow_out(overflow_out));
`default_nettype wire

//--- verification/event_source.sv
`timescale 1ns/1ps
`default_nettype none
// External event source; keeps same-line edges apart
module event_source #(
	parameter int LINES = 4
) (
	// Clock
	input wire logic clock_in,
	// Event lines
	output logic [LINES-1:0] event_lines_out
);
	int last [LINES] = '{default: -100};
	int now = 0;
	initial event_lines_out = '0;
	always @(posedge clock_in) now <= now + 1;
	// Closer edges on one line would merge, so wait them out; the cycle
	// count is read after the edge has settled, giving at least nine
	task automatic fire(input logic [LINES-1:0] m);
		@(posedge clock_in);
		#1;
		for (int i = 0; i < LINES; i++) begin
			while (m[i] && now - last[i] < 9) begin
				@(posedge clock_in);
				#1;
			end
		end
		event_lines_out = event_lines_out ^ m;
		for (int i = 0; i < LINES; i++)
			if (m[i]) last[i] = now;
	endtask : fire
endmodule : event_source
`default_nettype wire

//--- verification/event_time_capture_fifo_bench.sv
`timescale 1ns/1ps
`default_nettype none
module event_time_capture_fifo_bench;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic hold_read = 1'b0;
	logic [3:0] ev;
	logic hold_valid;
	logic [3:0] hold_lines;
	logic [15:0] hold_tag;
	logic [15:0] timer;
	logic overflow;
	int n_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	logic [3:0] q_lines [$];
	logic [15:0] q_tag [$];
	int q_at [$];
	always #10 clock_in = ~clock_in;
	event_source #(.LINES(4)) src (.clock_in(clock_in), .event_lines_out(ev));
	event_time_capture_fifo dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.event_lines_in(ev), .hold_read_in(hold_read), .hold_valid_out(hold_valid),
		.hold_lines_out(hold_lines), .hold_tag_out(hold_tag), .timer_out(timer),
		.overflow_out(overflow));
	task automatic summarize();
		$display("checks %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	// Hang guard, well above the whole sequence
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Reads entries one-cycle pulses at a time until 30 idle cycles pass
	task automatic drain();
		int idle;
		idle = 0;
		q_lines.delete();
		q_tag.delete();
		q_at.delete();
		while (idle < 30) begin
			@(posedge clock_in);
			#1;
			hold_read = (hold_valid === 1'b1) && !hold_read;
			idle = (hold_valid === 1'b1) ? 0 : idle + 1;
			if (hold_read) begin
				q_lines.push_back(hold_lines);
				q_tag.push_back(hold_tag);
				q_at.push_back(cyc);
			end
		end
	endtask : drain
	task automatic t_single();
		logic [15:0] t;
		int c;
		src.fire(4'h1);
		t = timer;
		c = cyc;
		drain();
		check("count", q_tag.size(), 1);
		check("lines", q_lines[0], 4'h1);
		check("tag", 16'(q_tag[0] - t) <= 1, 1);
		check("delay", (q_at[0] - c) inside {[8:20]}, 1);
	endtask : t_single
	// Two lines in one phase share a tag
	task automatic t_same();
		logic [3:0] u;
		u = 4'h0;
		src.fire(4'h6);
		drain();
		foreach (q_tag[i]) begin
			u |= q_lines[i];
			check("same tag", q_tag[i], q_tag[0]);
		end
		check("union", u, 4'h6);
	endtask : t_same
	task automatic t_near();
		src.fire(4'h1);
		repeat (8) @(posedge clock_in);
		src.fire(4'h8);
		drain();
		check("near count", q_tag.size(), 2);
		check("near step", 16'(q_tag[1] - q_tag[0]) inside {1, 2}, 1);
	endtask : t_near
	// Event after the first moved to holding starts afresh
	task automatic t_late();
		logic [15:0] t;
		src.fire(4'h1);
		repeat (30) @(posedge clock_in);
		src.fire(4'h2);
		t = timer;
		drain();
		check("late count", q_tag.size(), 2);
		check("late lines", q_lines[1], 4'h2);
		check("late tag", 16'(q_tag[1] - t) <= 1, 1);
	endtask : t_late
	// Overfill: holding plus eight stored, the rest dropped
	task automatic t_full();
		repeat (11) src.fire(4'h1);
		repeat (12) @(posedge clock_in);
		#1;
		check("overflow", overflow, 1'b1);
		drain();
		check("kept", q_tag.size(), 9);
		for (int i = 1; i < q_tag.size(); i++)
			check("step", 16'(q_tag[i] - q_tag[i-1]) inside {1, 2}, 1);
		check("cleared", overflow, 1'b0);
	endtask : t_full
	initial begin
		repeat (20) @(posedge clock_in);
		#1;
		rst_n_in = 1'b1;
		@(posedge clock_in);
		#1;
		check("reset", {hold_valid, overflow, timer}, 18'h0);
		t_single();
		t_same();
		t_near();
		t_late();
		t_full();
		summarize();
	end
endmodule : event_time_capture_fifo_bench
`default_nettype wire
